// ===== logic/sgl_pkg.sv
// sgl_pkg: shared constants, states and bundles of the gate switch lock logic
// assumes a single 200 MHz clock and a millisecond tick built from it
package sgl_pkg;
   // clock and timebase
   localparam int SGL_CLOCK_PERIOD_NS = 5;
   localparam int SGL_TICK_PERIOD_NS = 1000000;
   localparam int SGL_TICK_CYCLES = SGL_TICK_PERIOD_NS / SGL_CLOCK_PERIOD_NS;
   // intervals in milliseconds, counted in ticks
   localparam int SGL_LOCK_TIMEOUT_MS = 600;
   localparam int SGL_REQ_LOW_MS = 500;
   localparam int SGL_MS_WIDTH = 10;
   // extra power-up holding-force attempts after the first
   localparam logic [2:0] SGL_TEST_RETRIES = 3'h7;
   // reset values
   localparam logic [1:0] SGL_OUTPUTS_RESET = 2'h0;

   // lock status states, one-hot
   typedef enum logic [6:0] {
      SGL_ST_INIT    = 7'h01,
      SGL_ST_OPEN    = 7'h02,
      SGL_ST_CLOSED  = 7'h04,
      SGL_ST_TEST    = 7'h08,
      SGL_ST_LOCKING = 7'h10,
      SGL_ST_LOCKED  = 7'h20,
      SGL_ST_FAULT   = 7'h40
   } sgl_state_type;

   // pin inputs as one bundle so the synchroniser treats them alike
   typedef struct packed {
      logic act;   // actuator in range
      logic ch1;   // safety input channel 1
      logic ch2;   // safety input channel 2
      logic req;   // lock request
      logic hold;  // holding force reached
      logic diag;  // internal diagnostic fault
   } sgl_pins_type;

   // indications
   typedef struct packed {
      logic unequal_status;
      logic partial_lock;
      logic lock_fault;
      logic general_fault;
   } sgl_status_type;
endpackage

// ===== logic/sgl_ms_timer.sv
// sgl_ms_timer: counts millisecond ticks while enabled, flags when the limit is reached
// assumes tick is a one-cycle pulse on the same clock
module sgl_ms_timer #(
   parameter int WIDTH = 10,
   parameter logic [WIDTH-1:0] LIMIT = '1
) (
   input wire logic clock, // system clock
   input wire logic rst, // async reset, active high
   input wire logic tick, // millisecond pulse
   input wire logic run, // count while high, clear while low
   input wire logic restart, // clear and start again
   output logic done // limit reached, level
);
   logic [WIDTH-1:0] count;
   logic [WIDTH-1:0] next_count;

   // saturate at the limit so done stays until the timer is cleared
   always_comb begin
      next_count = count;
      if (!run || restart) begin
         next_count = '0;
      end else if (tick && count != LIMIT) begin
         next_count = count + 1'b1;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

   assign done = (count == LIMIT);
endmodule

// ===== logic/sgl_gate_lock.sv
// sgl_gate_lock: safety outputs, plausibility monitor and magnetic lock control of a gate switch
// assumes all inputs arrive asynchronously from pins or the transponder front end
// Overview of operation
// [RQ1] outputs high only when actuator and both inputs high
// [RQ2] outputs low if actuator gone or inputs low
// [RQ3] lock status high while actuator in range; code keeps it low in SGL_ST_INIT and SGL_ST_FAULT
// [RQ4] locking request needs holding force within 600 ms
// [RQ5] request low keeps status high while closed
// [RQ6] status drops once actuator leaves range
// [RQ7] lock timeout faults; recover after 500 ms low
// [RQ8] one channel falling alone flags unequal status
// [RQ9] falling channel rising again locks outputs off
// [RQ10] both channels low together restores normal operation
// [RQ11] magnet on only with request and actuator
// [RQ12] power-up force test, seven further retries
// [RQ13] power-up retries leave status alone until success
// [RQ14] controller keeps request low 500 ms minimum
// [RQ15] forced opening turns safety outputs off
// [RQ16] outputs ignore lock state entirely
// [RQ17] lock fault on timeout or forced opening
// [RQ18] partial operation shown until both channels open
// [RQ19] general fault latches until power cycle
// [RQ20] ms tick timebase, inputs synchronised first
// [RQ21] reset starts with outputs, magnet, status low
module sgl_gate_lock #(
   parameter int TICK_CYCLES = sgl_pkg::SGL_TICK_CYCLES
) (
   input wire logic clock, // 200 MHz system clock
   input wire logic rst, // async reset, active high
   input wire logic actuator_in_range, // transponder sees actuator
   input wire logic safety_in_ch1, // chained safety input 1
   input wire logic safety_in_ch2, // chained safety input 2
   input wire logic lock_request_in, // lock/unlock command
   input wire logic holding_force_ok, // magnet monitor: force reached
   input wire logic diag_fault_in, // internal self-test failure
   output logic [1:0] safety_switching_output, // two redundant safety outputs
   output logic lock_status_out, // lock signal output
   output logic magnet_on, // locking magnet drive
   output sgl_pkg::sgl_status_type status // indications
);
   import sgl_pkg::*;

   sgl_pins_type pins_raw;
   sgl_pins_type sync1;
   sgl_pins_type sync2;
   logic act, ch1, ch2, req, force_ok;
   logic [31:0] pre;
   logic [31:0] next_pre;
   logic tick;
   logic lock_done, low_done, lock_run, lock_restart;
   sgl_state_type state;
   sgl_state_type next_state;
   logic [2:0] tries;
   logic [2:0] next_tries;
   logic both_high_q, unequal, partial, gen_fault;
   logic next_both_high, next_unequal, next_partial, next_gen_fault;
   logic next_safe_on, next_status_hi, next_magnet, next_lock_fault;

   // two-stage synchroniser; only sync2 is read by logic [RQ20]
   assign pins_raw = '{act: actuator_in_range, ch1: safety_in_ch1, ch2: safety_in_ch2,
                       req: lock_request_in, hold: holding_force_ok, diag: diag_fault_in};
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= pins_raw;
         sync2 <= sync1;
      end
   end
   assign act = sync2.act;
   assign ch1 = sync2.ch1;
   assign ch2 = sync2.ch2;
   assign req = sync2.req;
   assign force_ok = sync2.hold;

   // millisecond prescaler; shorten TICK_CYCLES in simulation [RQ20]
   always_comb begin
      next_pre = pre + 32'h1;
      if (pre == 32'(TICK_CYCLES - 1)) begin
         next_pre = 32'h0;
      end
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pre <= 32'h0;
      end else begin
         pre <= next_pre;
      end
   end
   assign tick = (pre == 32'(TICK_CYCLES - 1));

   // holding-force timeout, restarted for each power-up attempt [RQ4] [RQ12]
   assign lock_run = (state == SGL_ST_TEST) || (state == SGL_ST_LOCKING);
   assign lock_restart = (state == SGL_ST_TEST) && lock_done;
   sgl_ms_timer #(.WIDTH(SGL_MS_WIDTH), .LIMIT(SGL_MS_WIDTH'(SGL_LOCK_TIMEOUT_MS))) u_lock_timer (
      .clock(clock),
      .rst(rst),
      .tick(tick),
      .run(lock_run),
      .restart(lock_restart),
      .done(lock_done)
   );

   // request-low interval; cleared the moment the request rises [RQ7]
   sgl_ms_timer #(.WIDTH(SGL_MS_WIDTH), .LIMIT(SGL_MS_WIDTH'(SGL_REQ_LOW_MS))) u_low_timer (
      .clock(clock),
      .rst(rst),
      .tick(tick),
      .run(!req),
      .restart(1'b0),
      .done(low_done)
   );

   // lock status state machine
   always_comb begin
      next_state = state;
      next_tries = tries;
      case (state)
         SGL_ST_INIT: begin
            // first evaluation waits one tick so the synchronisers have settled [RQ21]
            if (tick) begin
               if (!act) begin
                  next_state = SGL_ST_OPEN;
               end else if (req) begin
                  next_state = SGL_ST_TEST;
                  next_tries = 3'h0;
               end else begin
                  next_state = SGL_ST_CLOSED;
               end
            end
         end
         SGL_ST_OPEN: begin
            if (act) begin
               next_state = req ? SGL_ST_LOCKING : SGL_ST_CLOSED; // [RQ3]
            end
         end
         SGL_ST_CLOSED: begin
            if (!act) begin
               next_state = SGL_ST_OPEN; // [RQ6]
            end else if (req) begin
               next_state = SGL_ST_LOCKING;
            end
         end
         SGL_ST_TEST: begin
            // failed attempts keep status high; only exhaustion faults [RQ13]
            if (!act) begin
               next_state = SGL_ST_OPEN;
            end else if (!req) begin
               next_state = SGL_ST_CLOSED;
            end else if (force_ok) begin
               next_state = SGL_ST_LOCKED;
            end else if (lock_done) begin
               if (tries == SGL_TEST_RETRIES) begin
                  next_state = SGL_ST_FAULT; // [RQ12]
               end else begin
                  next_tries = tries + 3'h1;
               end
            end
         end
         SGL_ST_LOCKING: begin
            if (!req) begin
               next_state = act ? SGL_ST_CLOSED : SGL_ST_OPEN; // [RQ5]
            end else if (!act || (lock_done && !force_ok)) begin
               next_state = SGL_ST_FAULT; // [RQ4] [RQ17]
            end else if (force_ok) begin
               next_state = SGL_ST_LOCKED;
            end
         end
         SGL_ST_LOCKED: begin
            if (!req) begin
               next_state = act ? SGL_ST_CLOSED : SGL_ST_OPEN;
            end else if (!act) begin
               next_state = SGL_ST_FAULT; // forced opening [RQ17]
            end
         end
         SGL_ST_FAULT: begin
            // only a long enough low phase followed by a rise recovers [RQ7]
            if (req && low_done) begin
               next_state = act ? SGL_ST_LOCKING : SGL_ST_OPEN;
            end
         end
         default: begin
            next_state = SGL_ST_INIT;
         end
      endcase
   end

   // plausibility monitor and latched general fault
   always_comb begin
      next_both_high = ch1 && ch2;
      next_unequal = unequal;
      next_partial = partial;
      next_gen_fault = gen_fault || sync2.diag; // no clear except reset [RQ19]
      if (!ch1 && !ch2) begin
         next_unequal = 1'b0; // [RQ10] [RQ18]
         next_partial = 1'b0;
      end else if (both_high_q && (ch1 ^ ch2)) begin
         next_unequal = 1'b1; // [RQ8]
      end else if (unequal && ch1 && ch2) begin
         next_partial = 1'b1; // [RQ9]
      end
   end

   // safety outputs depend on actuator, inputs, plausibility lock and general fault, never on lock state [RQ16]
   always_comb begin
      next_safe_on = act && ch1 && ch2 && !next_partial && !next_gen_fault; // [RQ1] [RQ2] [RQ15]
      next_status_hi = (next_state == SGL_ST_CLOSED) || (next_state == SGL_ST_TEST) ||
                       (next_state == SGL_ST_LOCKING) || (next_state == SGL_ST_LOCKED); // [RQ3]
      next_magnet = (next_state == SGL_ST_TEST) || (next_state == SGL_ST_LOCKING) ||
                    (next_state == SGL_ST_LOCKED); // [RQ11]
      next_lock_fault = (next_state == SGL_ST_FAULT); // [RQ17]
   end

   // all flags and outputs start low, state starts in SGL_ST_INIT [RQ21]
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state <= SGL_ST_INIT;
         tries <= 3'h0;
         both_high_q <= 1'b0;
         unequal <= 1'b0;
         partial <= 1'b0;
         gen_fault <= 1'b0;
         safety_switching_output <= SGL_OUTPUTS_RESET;
         lock_status_out <= 1'b0;
         magnet_on <= 1'b0;
         status <= '0;
      end else begin
         state <= next_state;
         tries <= next_tries;
         both_high_q <= next_both_high;
         unequal <= next_unequal;
         partial <= next_partial;
         gen_fault <= next_gen_fault;
         safety_switching_output <= {next_safe_on, next_safe_on};
         lock_status_out <= next_status_hi;
         magnet_on <= next_magnet;
         status <= '{unequal_status: next_unequal, partial_lock: next_partial,
                     lock_fault: next_lock_fault, general_fault: next_gen_fault};
      end
   end

   // helper for the timeout check: fault shown with status and magnet both released
   logic lock_fault_seen;
   assign lock_fault_seen = status.lock_fault && !lock_status_out && !magnet_on;

   // checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   sequence seq_fault_waiting;
      state == SGL_ST_FAULT && req && !low_done;
   endsequence

   sequence seq_last_try_failed;
      state == SGL_ST_TEST && tries == SGL_TEST_RETRIES && lock_done && act && req && !force_ok;
   endsequence

   sequence seq_lock_expired;
      state == SGL_ST_LOCKING && lock_done && req && !force_ok;
   endsequence

   chk_outputs_need_all: assert property (safety_switching_output[0] |-> $past(act && ch1 && ch2)) // [RQ1]
      else $error("safety output high without actuator and both inputs");
   chk_outputs_drop: assert property ((!act || !ch1 || !ch2) |=> safety_switching_output == 2'h0) // [RQ2]
      else $error("safety outputs not dropped");
   chk_status_open: assert property (!act |=> !lock_status_out) // [RQ6]
      else $error("lock status high with actuator absent");
   chk_magnet_gate: assert property (magnet_on |-> $past(req && act)) // [RQ11]
      else $error("magnet on without request and actuator");
   chk_lock_timeout: assert property (seq_lock_expired |=> lock_fault_seen) // [RQ4]
      else $error("lock timeout did not fault");
   chk_fault_hold: assert property (seq_fault_waiting |=> state == SGL_ST_FAULT && !lock_status_out) // [RQ7]
      else $error("fault left without 500 ms low request");
   chk_unequal_flag: assert property ((both_high_q && (ch1 ^ ch2)) |=> status.unequal_status) // [RQ8]
      else $error("unequal status not flagged");
   chk_plaus_lock: assert property ((unequal && ch1 && ch2) |=> partial ##0 safety_switching_output == 2'h0) // [RQ9]
      else $error("plausibility lock not entered");
   chk_partial_clear: assert property ((partial && !ch1 && !ch2) |=> !partial && !status.partial_lock) // [RQ10]
      else $error("partial lock not cleared by both channels low");
   chk_retry_bound: assert property (seq_last_try_failed |=> state == SGL_ST_FAULT) // [RQ12]
      else $error("last power-up attempt failed without fault");
   chk_fault_sticky: assert property (status.general_fault |=> status.general_fault) // [RQ19]
      else $error("general fault cleared without reset");

endmodule

// ===== dv/sgl_ctrl_model.sv
// sgl_ctrl_model: far-side controller and magnet force monitor for the gate lock
// assumes the bench sets req_cmd and force_dly on the rising clock edge
module sgl_ctrl_model #(
   parameter int TICK_CYCLES = 10
) (
   input wire logic clock, // system clock
   input wire logic rst, // async reset, active high
   input wire logic req_cmd, // bench wants the gate locked
   input wire logic [15:0] force_dly, // cycles from magnet on to force, FFFF never
   input wire logic magnet_on, // magnet drive from the block
   output logic lock_request_in, // request towards the block
   output logic holding_force_ok // force monitor towards the block
);
   timeunit 1ns;
   timeprecision 1ps;
   int low_cnt;
   int mag_cnt;

   // a new request waits out a full low span; reset counts as a long rest
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         lock_request_in <= 1'b0;
         low_cnt <= 510 * TICK_CYCLES;
      end else begin
         low_cnt <= lock_request_in ? 0 : low_cnt + 1;
         lock_request_in <= req_cmd && (lock_request_in || low_cnt >= 510 * TICK_CYCLES);
      end
   end

   // force builds a set time after energising and is lost at once when it drops
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         mag_cnt <= 0;
         holding_force_ok <= 1'b0;
      end else begin
         mag_cnt <= magnet_on ? mag_cnt + 1 : 0;
         holding_force_ok <= magnet_on && force_dly != 16'hFFFF && mag_cnt >= int'(force_dly);
      end
   end
endmodule

// ===== dv/sgl_gate_lock_tb.sv
// sgl_gate_lock_tb: self-checking bench for the gate switch lock logic
// assumes sgl_pkg is compiled first; a 10-cycle tick makes 1 ms ten clocks
module sgl_gate_lock_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import sgl_pkg::*;
   localparam int TK = 10;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic actuator_in_range = 1'b1;
   logic safety_in_ch1 = 1'b1;
   logic safety_in_ch2 = 1'b1;
   logic req_cmd = 1'b1;
   logic [15:0] force_dly = 16'hFFFF;
   logic diag_fault_in = 1'b0;
   logic lock_request_in;
   logic holding_force_ok;
   logic lock_status_out;
   logic magnet_on;
   logic [1:0] safety_switching_output;
   sgl_status_type status;
   int bad_count = 0;
   int tests_run = 0;

   // 200 MHz clock
   initial begin
      forever #2.5 clock = ~clock;
   end

   sgl_gate_lock #(.TICK_CYCLES(TK)) DUT (.clock(clock), .rst(rst), .actuator_in_range(actuator_in_range),
      .safety_in_ch1(safety_in_ch1), .safety_in_ch2(safety_in_ch2), .lock_request_in(lock_request_in),
      .holding_force_ok(holding_force_ok), .diag_fault_in(diag_fault_in),
      .safety_switching_output(safety_switching_output), .lock_status_out(lock_status_out),
      .magnet_on(magnet_on), .status(status));

   sgl_ctrl_model #(.TICK_CYCLES(TK)) ctrl (.clock(clock), .rst(rst), .req_cmd(req_cmd), .force_dly(force_dly),
      .magnet_on(magnet_on), .lock_request_in(lock_request_in), .holding_force_ok(holding_force_ok));

   // outputs packed as safety pair, lock status, magnet, then the four flags
   function automatic logic [7:0] obs();
      return {safety_switching_output, lock_status_out, magnet_on, status};
   endfunction

   // sample mid-cycle so the edge's updates have landed
   task automatic check(input logic [7:0] mask, input logic [7:0] exp);
      @(negedge clock);
      tests_run++;
      if ((obs() & mask) !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %0h expected %0h", $time, obs() & mask, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask

   task automatic drive(input logic a, input logic c1, input logic c2, input logic r);
      @(posedge clock);
      actuator_in_range <= a;
      safety_in_ch1 <= c1;
      safety_in_ch2 <= c2;
      req_cmd <= r;
   endtask

   task automatic step(input logic a, input logic c1, input logic c2, input logic r, input int n,
      input logic [7:0] mask, input logic [7:0] exp);
      drive(a, c1, c2, r);
      cyc(n);
      check(mask, exp);
   endtask

   task automatic stop_test();
      $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // power-up with gate closed, request high and a magnet that never holds
   task automatic t_powerup();
      cyc(3);
      rst <= 1'b0;
      cyc(2 * TK);
      check(8'hFF, 8'hF0);
      cyc(4200 * TK);
      check(8'hEF, 8'hE0);
      cyc(700 * TK);
      check(8'hFF, 8'hC2);
   endtask

   task automatic do_reset();
      @(posedge clock);
      rst <= 1'b1;
      check(8'hFF, 8'h00);
      cyc(3);
      rst <= 1'b0;
      check(8'hFF, 8'h00);
   endtask

   task automatic t_gate();
      step(1, 1, 1, 0, 4 * TK, 8'hFF, 8'hE0);
      step(0, 1, 1, 0, 8, 8'hFF, 8'h00);
      step(1, 0, 0, 0, 8, 8'hFF, 8'h20);
      step(1, 1, 1, 0, 8, 8'hFF, 8'hE0);
   endtask

   // each channel in turn drops alone, comes back, then both open together
   task automatic t_plaus();
      for (int i = 0; i < 2; i++) begin
         step(1, i[0], !i[0], 0, 8, 8'hFF, 8'h28);
         step(1, 1, 1, 0, 8, 8'hFF, 8'h2C);
         step(1, 0, 0, 0, 8, 8'hFF, 8'h20);
         step(1, 1, 1, 0, 8, 8'hFF, 8'hE0);
      end
   endtask

   task automatic t_lock();
      @(posedge clock);
      force_dly <= 16'h0064;
      step(1, 1, 1, 1, 8, 8'hFF, 8'hF0);
      cyc(700 * TK);
      check(8'hFF, 8'hF0);
      step(0, 1, 1, 1, 8, 8'hFF, 8'h02);
      drive(1, 1, 1, 0);
      cyc(520 * TK);
      step(1, 1, 1, 1, 30, 8'hFF, 8'hF0);
   endtask

   // request dropped with the gate closed, then a request whose force never arrives times out and faults; a later request recovers
   task automatic t_timeout();
      step(1, 1, 1, 0, 8, 8'hFF, 8'hE0);
      cyc(520 * TK);
      force_dly <= 16'hFFFF;
      step(1, 1, 1, 1, 590 * TK, 8'hFF, 8'hF0);
      cyc(15 * TK);
      check(8'hFF, 8'hC2);
      step(1, 1, 1, 0, 8, 8'hFF, 8'hC2);
      cyc(520 * TK);
      force_dly <= 16'h0064;
      step(1, 1, 1, 1, 30, 8'hFF, 8'hF0);
   endtask

   // a diagnostic fault must outlive its cause
   task automatic t_diag();
      @(posedge clock);
      diag_fault_in <= 1'b1;
      cyc(8);
      check(8'hC1, 8'h01);
      @(posedge clock);
      diag_fault_in <= 1'b0;
      cyc(8);
      check(8'hC1, 8'h01);
   endtask

   // power-up test fails once, holds on the second attempt; a forced opening then faults
   task automatic t_retry();
      @(posedge clock);
      force_dly <= 16'h1964;
      do_reset();
      cyc(700 * TK);
      check(8'hFF, 8'hF0);
      step(0, 1, 1, 1, 8, 8'hFF, 8'h02);
   endtask

   initial begin
      t_powerup();
      drive(1, 1, 1, 0);
      do_reset();
      t_gate();
      t_plaus();
      t_lock();
      t_timeout();
      t_diag();
      t_retry();
      stop_test();
   end

   // watchdog: the sequence needs about 85k cycles, so allow 95k
   initial begin
      #475000;
      bad_count++;
      stop_test();
   end
endmodule
